/* pkg/rcf_defines.svh */
// Register indices, field positions, key values and timing for the reset controller
`ifndef RCF_DEFINES_SVH
`define RCF_DEFINES_SVH
// Register indices; byte address is four times the index
`define RCF_IDX_CAUSE   8'hA1
`define RCF_IDX_TRIG    8'hE7
`define RCF_IDX_KEY     8'hF7
`define RCF_IDX_STATUS  8'hC0
`define RCF_IDX_LSB     2
`define RCF_IDX_MSB     9
`define RCF_ADDR_W      12
// Reset values
`define RCF_RST_CAUSE   8'h00
`define RCF_RST_TRIG    8'h00
`define RCF_RST_KEY     8'h00
// Cause flag bit positions
`define RCF_BIT_PAD     4
`define RCF_BIT_WDT     3
`define RCF_BIT_SW      2
`define RCF_BIT_LVR     1
`define RCF_BIT_POR     0
// Unlock keys and trigger value
`define RCF_KEY_1       8'h55
`define RCF_KEY_2       8'hAA
`define RCF_KEY_3       8'h5A
`define RCF_TRIG_FIRE   8'hFF
// Stretch times in ms and clock rate
`define RCF_CLK_HZ      25000000
`define RCF_MS_PER_S    1000
`define RCF_T200_MS     200
`define RCF_T100_MS     100
`define RCF_T50_MS      50
`define RCF_T25_MS      25
`define RCF_T16_MS      16
`define RCF_T8_MS       8
`define RCF_T4_MS       4
`define RCF_CYC(ms)     ((ms) * (`RCF_CLK_HZ / `RCF_MS_PER_S))
// Clock source code used during initialization, and the last valid code
`define RCF_CLK_XTAL    3'h0
`define RCF_CLK_LAST    3'h6
`endif

/* pkg/rcf_pkg.sv */
// Types shared by the reset controller modules
package rcf_pkg;
  // Register selected by a bus address
  typedef enum logic [2:0] {
    RCF_SEL_NONE   = 3'b000,
    RCF_SEL_CAUSE  = 3'b001,
    RCF_SEL_TRIG   = 3'b010,
    RCF_SEL_KEY    = 3'b011,
    RCF_SEL_STATUS = 3'b100
  } rcf_sel_e;
  // Progress through the unlock key sequence
  typedef enum logic [1:0] {
    RCF_UL_IDLE = 2'b00,
    RCF_UL_GOT1 = 2'b01,
    RCF_UL_GOT2 = 2'b10,
    RCF_UL_OPEN = 2'b11
  } rcf_unlock_e;
endpackage : rcf_pkg

/* pkg/rcf_stretch_if.sv */
// Link between the controller and its reset stretch timer
`timescale 1ns/10ps
`default_nettype none
interface rcf_stretch_if;
  logic       src;
  logic [2:0] sel;
  logic       busy;
  logic       done;
  modport ctrl  (output src, output sel, input busy, input done);
  modport timer (input src, input sel, output busy, output done);
endinterface : rcf_stretch_if
`default_nettype wire

/* core/rcf_stretch.sv */
// Reset stretch timer: holds busy until the selected time has run out after all sources fall
`timescale 1ns/10ps
`default_nettype none
`include "rcf_defines.svh"
module rcf_stretch
  import rcf_pkg::*;
#(
  parameter int CNT_W    = 23,
  parameter int T200_CYC = `RCF_CYC(`RCF_T200_MS),
  parameter int T100_CYC = `RCF_CYC(`RCF_T100_MS),
  parameter int T50_CYC  = `RCF_CYC(`RCF_T50_MS),
  parameter int T25_CYC  = `RCF_CYC(`RCF_T25_MS),
  parameter int T16_CYC  = `RCF_CYC(`RCF_T16_MS),
  parameter int T8_CYC   = `RCF_CYC(`RCF_T8_MS),
  parameter int T4_CYC   = `RCF_CYC(`RCF_T4_MS)
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Controller side
  rcf_stretch_if.timer st
);
  logic [CNT_W-1:0] cnt_reg;

  // Code 0 is the default; an unused code falls back to it
  function automatic logic [CNT_W-1:0] dur(input logic [2:0] s);
    unique case (s)
      3'h1:    dur = CNT_W'(T200_CYC);
      3'h2:    dur = CNT_W'(T100_CYC);
      3'h3:    dur = CNT_W'(T50_CYC);
      3'h4:    dur = CNT_W'(T16_CYC);
      3'h5:    dur = CNT_W'(T8_CYC);
      3'h6:    dur = CNT_W'(T4_CYC);
      default: dur = CNT_W'(T25_CYC);
    endcase
  endfunction : dur

  // Any live source reloads the full time, so the stretch is measured from the last release
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= dur(st.sel);
      st.busy <= 1'b1;
      st.done <= 1'b0;
    end
    else if (st.src)
    begin
      cnt_reg <= dur(st.sel);
      st.busy <= 1'b1;
      st.done <= 1'b0;
    end
    else if (cnt_reg > CNT_W'(1))
    begin
      cnt_reg <= cnt_reg - CNT_W'(1);
      st.done <= 1'b0;
    end
    else
    begin
      cnt_reg <= '0;
      st.done <= st.busy;
      st.busy <= 1'b0;
    end
  end
endmodule : rcf_stretch
`default_nettype wire

/* core/rcf_reset_ctrl.sv */
// Chip reset controller with software reset, unlock keys and reset cause flags
`timescale 1ns/10ps
`default_nettype none
`include "rcf_defines.svh"
module rcf_reset_ctrl
  import rcf_pkg::*;
#(
  parameter int CNT_W    = 23,
  parameter int T200_CYC = `RCF_CYC(`RCF_T200_MS),
  parameter int T100_CYC = `RCF_CYC(`RCF_T100_MS),
  parameter int T50_CYC  = `RCF_CYC(`RCF_T50_MS),
  parameter int T25_CYC  = `RCF_CYC(`RCF_T25_MS),
  parameter int T16_CYC  = `RCF_CYC(`RCF_T16_MS),
  parameter int T8_CYC   = `RCF_CYC(`RCF_T8_MS),
  parameter int T4_CYC   = `RCF_CYC(`RCF_T4_MS)
) (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  // Hardware reset sources, active high levels
  input  wire logic                   pad_reset_in,
  input  wire logic                   watchdog_reset_in,
  input  wire logic                   low_voltage_reset_in,
  input  wire logic                   power_on_reset_in,
  // Nonvolatile configuration
  input  wire logic [2:0]             reset_time_sel_in,
  input  wire logic [2:0]             clock_source_sel_in,
  // Chip outputs
  output logic                        chip_reset_out,
  output logic                        init_stage_out,
  output logic [2:0]                  clock_source_out,
  // AXI4-Lite write address and data
  input  wire logic [`RCF_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [31:0]            s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp_out,
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [`RCF_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  output logic [31:0]                 s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in
);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  rcf_stretch_if st ();

  logic [`RCF_ADDR_W-1:0] awaddr_reg;
  logic [7:0]             wdata_reg;
  logic                   wstrb_reg;
  logic                   wr_fire;
  rcf_sel_e               wr_sel;
  rcf_sel_e               rd_sel;
  logic [7:0]             cause_reg;
  logic [7:0]             trig_reg;
  logic [7:0]             key_reg;
  rcf_unlock_e            unlock_reg;
  logic                   soft_req_reg;
  logic [2:0]             clk_cfg_reg;
  logic [2:0]             clk_pick;
  logic [4:0]             cause_set;
  logic                   wr_cause;
  logic                   wr_trig;
  logic                   wr_key;

  // Shared address decode for both bus directions
  function automatic rcf_sel_e decode(input logic [`RCF_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[`RCF_IDX_MSB:`RCF_IDX_LSB];
    if (a[`RCF_IDX_LSB-1:0] != 2'b00 || a[`RCF_ADDR_W-1:`RCF_IDX_MSB+1] != '0)
      decode = RCF_SEL_NONE;
    else if (idx == `RCF_IDX_CAUSE)
      decode = RCF_SEL_CAUSE;
    else if (idx == `RCF_IDX_TRIG)
      decode = RCF_SEL_TRIG;
    else if (idx == `RCF_IDX_KEY)
      decode = RCF_SEL_KEY;
    else if (idx == `RCF_IDX_STATUS)
      decode = RCF_SEL_STATUS;
    else
      decode = RCF_SEL_NONE;
  endfunction : decode

  // Stretch timer instance
  rcf_stretch #(
    .CNT_W    (CNT_W),
    .T200_CYC (T200_CYC),
    .T100_CYC (T100_CYC),
    .T50_CYC  (T50_CYC),
    .T25_CYC  (T25_CYC),
    .T16_CYC  (T16_CYC),
    .T8_CYC   (T8_CYC),
    .T4_CYC   (T4_CYC)
  ) u_stretch (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .st          (st.timer)
  );

  // Software request joins the hardware sources in one OR
  assign st.src = pad_reset_in | watchdog_reset_in | low_voltage_reset_in
                | power_on_reset_in | soft_req_reg;
  assign st.sel = reset_time_sel_in;

  // Write address capture; ready drops until the response is taken
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_awready_out <= 1'b1;
      awaddr_reg        <= '0;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      s_axi_awready_out <= 1'b0;
      awaddr_reg        <= s_axi_awaddr_in;
    end
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_awready_out <= 1'b1;
  end

  // Write data capture; only the low byte lane carries register data
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_wready_out <= 1'b1;
      wdata_reg        <= 8'h00;
      wstrb_reg        <= 1'b0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      s_axi_wready_out <= 1'b0;
      wdata_reg        <= s_axi_wdata_in[7:0];
      wstrb_reg        <= s_axi_wstrb_in[0];
    end
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_wready_out <= 1'b1;
  end

  // A write takes effect once both halves are held and no response is pending
  assign wr_fire  = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  assign wr_sel   = decode(awaddr_reg);
  assign wr_cause = wr_fire && wstrb_reg && wr_sel == RCF_SEL_CAUSE;
  assign wr_trig  = wr_fire && wstrb_reg && wr_sel == RCF_SEL_TRIG;
  assign wr_key   = wr_fire && wstrb_reg && wr_sel == RCF_SEL_KEY;

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (wr_sel == RCF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // Key register keeps the last value written for readback
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      key_reg <= `RCF_RST_KEY;
    else if (wr_key)
      key_reg <= wdata_reg;
  end

  // Unlock tracker; stays open until the next chip reset
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || st.busy)
      unlock_reg <= RCF_UL_IDLE;
    else if (wr_key)
    begin
      unique case (unlock_reg)
        RCF_UL_IDLE:
          unlock_reg <= (wdata_reg == `RCF_KEY_1) ? RCF_UL_GOT1 : RCF_UL_IDLE;
        RCF_UL_GOT1:
          if (wdata_reg == `RCF_KEY_2)
            unlock_reg <= RCF_UL_GOT2;
          else if (wdata_reg == `RCF_KEY_1)
            unlock_reg <= RCF_UL_GOT1;
          else
            unlock_reg <= RCF_UL_IDLE;
        RCF_UL_GOT2:
          if (wdata_reg == `RCF_KEY_3)
            unlock_reg <= RCF_UL_OPEN;
          else if (wdata_reg == `RCF_KEY_1)
            unlock_reg <= RCF_UL_GOT1;
          else
            unlock_reg <= RCF_UL_IDLE;
        RCF_UL_OPEN:
          unlock_reg <= RCF_UL_OPEN;
      endcase
    end
  end

  // Trigger register: writable only when open, cleared as the reset ends
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      trig_reg <= `RCF_RST_TRIG;
    else if (st.done)
      trig_reg <= `RCF_RST_TRIG;
    else if (wr_trig && unlock_reg == RCF_UL_OPEN)
      trig_reg <= wdata_reg;
  end

  // One-cycle request; values other than the fire code do nothing
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      soft_req_reg <= 1'b0;
    else
      soft_req_reg <= wr_trig && unlock_reg == RCF_UL_OPEN
                      && wdata_reg == `RCF_TRIG_FIRE;
  end

  // Cause events, sampled while each source is live
  always_comb
  begin
    cause_set                 = '0;
    cause_set[`RCF_BIT_PAD]   = pad_reset_in;
    cause_set[`RCF_BIT_WDT]   = watchdog_reset_in;
    cause_set[`RCF_BIT_SW]    = soft_req_reg;
    cause_set[`RCF_BIT_LVR]   = low_voltage_reset_in;
    cause_set[`RCF_BIT_POR]   = power_on_reset_in;
  end

  // Writing zero clears a flag; a new cause in the same cycle wins over the clear
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      cause_reg <= `RCF_RST_CAUSE;
    else if (wr_cause)
      cause_reg <= {3'b000, (cause_reg[4:0] & wdata_reg[4:0]) | cause_set};
    else
      cause_reg <= {3'b000, cause_reg[4:0] | cause_set};
  end

  // Out-of-range codes fall back to the crystal
  assign clk_pick = (clock_source_sel_in > `RCF_CLK_LAST) ? `RCF_CLK_XTAL : clock_source_sel_in;

  // Configured source taken when initialization ends, so a change mid-run has no effect
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      clk_cfg_reg <= `RCF_CLK_XTAL;
    else if (st.done)
      clk_cfg_reg <= clk_pick;
  end

  // Chip-level outputs; crystal code held through the whole stretch
  // The done cycle forwards the fresh pick, so the new source shows as reset falls
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      chip_reset_out   <= 1'b1;
      init_stage_out   <= 1'b1;
      clock_source_out <= `RCF_CLK_XTAL;
    end
    else
    begin
      chip_reset_out   <= st.busy;
      init_stage_out   <= st.busy;
      clock_source_out <= st.busy ? `RCF_CLK_XTAL : (st.done ? clk_pick : clk_cfg_reg);
    end
  end

  // Read channel; one read in flight, data registered with the valid
  assign rd_sel = decode(s_axi_araddr_in);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= (rd_sel == RCF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rd_sel)
        RCF_SEL_CAUSE:  s_axi_rdata_out <= {24'h00_0000, cause_reg};
        RCF_SEL_TRIG:   s_axi_rdata_out <= {24'h00_0000, trig_reg};
        RCF_SEL_KEY:    s_axi_rdata_out <= {24'h00_0000, key_reg};
        RCF_SEL_STATUS: s_axi_rdata_out <= {24'h00_0000, unlock_reg == RCF_UL_OPEN,
                                            st.busy, 3'b000, clock_source_out};
        RCF_SEL_NONE:   s_axi_rdata_out <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end
endmodule : rcf_reset_ctrl
`default_nettype wire

/* bench/rcf_reset_ctrl_chk.sv */
// Checker on the reset controller ports: stretch length, clock choice and bus timing
`timescale 1ns/10ps
`default_nettype none
`include "rcf_defines.svh"
module rcf_reset_ctrl_chk
  import rcf_pkg::*;
#(
  parameter int T200_CYC = 20,
  parameter int T100_CYC = 10,
  parameter int T50_CYC  = 8,
  parameter int T25_CYC  = 6,
  parameter int T16_CYC  = 5,
  parameter int T8_CYC   = 4,
  parameter int T4_CYC   = 3
) (
  // Clock, reset, sources and configuration
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        pad_reset_in,
  input wire logic        watchdog_reset_in,
  input wire logic        low_voltage_reset_in,
  input wire logic        power_on_reset_in,
  input wire logic [2:0]  reset_time_sel_in,
  input wire logic [2:0]  clock_source_sel_in,
  // Chip outputs
  input wire logic        chip_reset_out,
  input wire logic        init_stage_out,
  input wire logic [2:0]  clock_source_out,
  // Bus handshakes
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  logic [7:0] quiet_reg;
  logic       any_src;
  int         n_cyc;
  // Any hardware source is a cause of chip reset
  assign any_src = pad_reset_in | watchdog_reset_in | low_voltage_reset_in | power_on_reset_in;
  // Stretch length for the configured code; codes 0 and 7 give the default
  always_comb
  begin
    case (reset_time_sel_in)
      3'h1: n_cyc = T200_CYC;
      3'h2: n_cyc = T100_CYC;
      3'h3: n_cyc = T50_CYC;
      3'h4: n_cyc = T16_CYC;
      3'h5: n_cyc = T8_CYC;
      3'h6: n_cyc = T4_CYC;
      default: n_cyc = T25_CYC;
    endcase
  end
  // Quiet cycles since the last source; saturates so a long idle never wraps
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || any_src)
      quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hFF)
      quiet_reg <= quiet_reg + 8'h01;
  end
  sequence s_src;
    any_src;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  property p_src_hold;
    s_src |-> ##2 chip_reset_out;
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source did not reset chip");
  property p_stretch_min;
    (int'(quiet_reg) < n_cyc) |=> chip_reset_out;
  endproperty
  a_stretch_min: assert property (p_stretch_min) else $error("reset released early");
  property p_stretch_end;
    (int'(quiet_reg) == n_cyc + 4) |-> !chip_reset_out;
  endproperty
  a_stretch_end: assert property (p_stretch_end) else $error("reset held too long");
  property p_init_stage;
    init_stage_out == chip_reset_out;
  endproperty
  a_init_stage: assert property (p_init_stage) else $error("init stage differs from reset");
  property p_xtal_init;
    chip_reset_out [*2] |-> clock_source_out == `RCF_CLK_XTAL;
  endproperty
  a_xtal_init: assert property (p_xtal_init) else $error("no crystal during init");
  property p_clk_pick;
    $fell(chip_reset_out) |-> clock_source_out == ((clock_source_sel_in == 3'h7) ? 3'h0 : clock_source_sel_in);
  endproperty
  a_clk_pick: assert property (p_clk_pick) else $error("wrong clock after init");
  property p_wr_resp;
    s_wr_take |-> ##[1:3] s_axi_bvalid_out;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_answer;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : rcf_reset_ctrl_chk
bind rcf_reset_ctrl rcf_reset_ctrl_chk #(.T200_CYC(T200_CYC), .T100_CYC(T100_CYC), .T50_CYC(T50_CYC),
  .T25_CYC(T25_CYC), .T16_CYC(T16_CYC), .T8_CYC(T8_CYC), .T4_CYC(T4_CYC)) rcf_reset_ctrl_chk_i (
  .core_clk_in, .rst_in, .pad_reset_in, .watchdog_reset_in, .low_voltage_reset_in, .power_on_reset_in,
  .reset_time_sel_in, .clock_source_sel_in, .chip_reset_out, .init_stage_out, .clock_source_out,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in);
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the reset controller
`timescale 1ns/10ps
`default_nettype none
module tb
  import rcf_pkg::*;
;
  localparam logic [11:0] A_CAUSE = 12'h284;
  localparam logic [11:0] A_TRIG  = 12'h39C;
  localparam logic [11:0] A_KEY   = 12'h3DC;
  localparam logic [11:0] A_NONE  = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h300;
  localparam logic [7:0]  FLAG [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
  logic        clk, rst, cr, cr_q, init, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
  logic [3:0]  srcs, wstrb;
  logic [2:0]  rt_sel, cs_sel, cs_out, c;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  v;
  logic [33:0] rq [$];
  logic [1:0]  bq [$];
  logic [2:0]  cq [$];
  int          err_count, num_checks;
  rcf_reset_ctrl #(.T200_CYC(20), .T100_CYC(10), .T50_CYC(8), .T25_CYC(6), .T16_CYC(5), .T8_CYC(4),
    .T4_CYC(3)) rcf_reset_ctrl_i (
    .core_clk_in(clk), .rst_in(rst), .pad_reset_in(srcs[0]), .watchdog_reset_in(srcs[1]),
    .low_voltage_reset_in(srcs[2]), .power_on_reset_in(srcs[3]), .reset_time_sel_in(rt_sel),
    .clock_source_sel_in(cs_sel), .chip_reset_out(cr), .init_stage_out(init), .clock_source_out(cs_out),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrdy));
  // Free-running 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wrap_up;
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  function automatic logic [33:0] ok(input logic [7:0] d);
    return {2'b00, 24'h00_0000, d};
  endfunction : ok
  // Write one byte; both channels offered together, bready raised after a random stall
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end
    while ((awv && !awr) || (wv && !wrdy));
    repeat ($urandom_range(2)) @(posedge clk);
    brdy <= 1'b1;
    do @(posedge clk); while (!bv);
    brdy <= 1'b0;
  endtask : wr
  // Read one register; the expected answer is noted before the request goes out
  task rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk);
    rrdy <= 1'b1;
    do @(posedge clk); while (!rv);
    rrdy <= 1'b0;
  endtask : rd
  task unlock(input logic [7:0] k3);
    wr(A_KEY, 8'h55, 2'b00);
    wr(A_KEY, 8'hAA, 2'b00);
    wr(A_KEY, k3, 2'b00);
  endtask : unlock
  // Wait out a chip reset, bounded, then let the stretch history age
  task idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (cr === 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 300)
      err_count++;
    repeat (30) @(posedge clk);
  endtask : idle
  // Takes the oldest note whenever a response or the end of a chip reset shows up
  always @(posedge clk)
  begin
    if (rv && rrdy)
      chk("read", {rresp, rdata}, rq.pop_front());
    if (bv && brdy)
      chk("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
    if (cr_q === 1'b1 && cr === 1'b0)
      chk("clock", {31'h0000_0000, cs_out}, {31'h0000_0000, cq.pop_front()});
    cr_q <= cr;
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(93));
    {rst, srcs, awv, wv, brdy, arv, rrdy} = {1'b1, 9'h000};
    {rt_sel, cs_sel, awaddr, araddr, wdata, wstrb} = {3'h0, 3'h3, 24'h00_0000, 32'h0000_0000, 4'hF};
    cq.push_back(3'h3);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle;
    // Reset values and an unmapped place
    rd(A_CAUSE, ok(8'h00));
    rd(A_KEY, ok(8'h00));
    rd(A_NONE, {2'b10, 32'h0000_0000});
    wr(A_NONE, 8'h12, 2'b10);
    // Locked trigger and a wrong third key both ignore a fire value
    wr(A_TRIG, 8'hFF, 2'b00);
    rd(A_TRIG, ok(8'h00));
    unlock(8'h00);
    wr(A_TRIG, 8'hFF, 2'b00);
    rd(A_TRIG, ok(8'h00));
    // Unlocked: other values do nothing, the fire value resets the chip
    unlock(8'h5A);
    rd(A_STATUS, ok(8'h83));
    v = 8'($urandom_range(254));
    wr(A_TRIG, v, 2'b00);
    rd(A_TRIG, ok(v));
    rd(A_CAUSE, ok(8'h00));
    c = 3'($urandom_range(7));
    cs_sel <= c;
    cq.push_back((c == 3'h7) ? 3'h0 : c);
    wr(A_TRIG, 8'hFF, 2'b00);
    idle;
    rd(A_TRIG, ok(8'h00));
    rd(A_CAUSE, ok(8'h04));
    // A clear without the low byte lane strobed leaves the flags alone
    wstrb <= {3'($urandom_range(7)), 1'b0};
    wr(A_CAUSE, 8'h00, 2'b00);
    wstrb <= 4'hF;
    rd(A_CAUSE, ok(8'h04));
    wr(A_TRIG, 8'hFF, 2'b00);
    rd(A_TRIG, ok(8'h00));
    // Each hardware source in turn, each under two of the eight stretch codes
    for (int k = 0; k < 8; k++)
    begin
      c = 3'($urandom_range(7));
      wr(A_CAUSE, 8'h00, 2'b00);
      rd(A_CAUSE, ok(8'h00));
      rt_sel <= 3'(k);
      cs_sel <= c;
      cq.push_back((c == 3'h7) ? 3'h0 : c);
      @(posedge clk);
      srcs[k % 4] <= 1'b1;
      repeat (1 + $urandom_range(3)) @(posedge clk);
      srcs <= 4'h0;
      idle;
      rd(A_CAUSE, ok(FLAG[k % 4]));
    end
    wrap_up;
  end
endmodule : tb
`default_nettype wire
